// ==== hw/tcc_regs.vh ====
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// Register offsets
`define TCC_ADDR_IDENTITY 8'h01
`define TCC_ADDR_CONTROL 8'h02
`define TCC_ADDR_EVENT 8'h03
`define TCC_ADDR_CC_STATUS 8'h04
`define TCC_ADDR_CONDET_CFG 8'h09
`define TCC_ADDR_VCONN 8'h0A
// Identity fields, values arbitrary
`define TCC_DEV_VERSION 5'h02
`define TCC_VENDOR 3'h5
// Control fields
`define TCC_CTL_MASK 0
`define TCC_CTL_ROLE_LO 1
`define TCC_CTL_ROLE_HI 2
`define TCC_CTL_RP_LO 3
`define TCC_CTL_RP_HI 4
`define TCC_RP_DEFAULT 2'h0
`define TCC_RP_MEDIUM 2'h1
`define TCC_RP_HIGH 2'h2
`define TCC_ROLE_UFP 2'h0
`define TCC_ROLE_DFP 2'h1
`define TCC_ROLE_DRP 2'h2
// Event status bits
`define TCC_EV_ATTACH 0
`define TCC_EV_DETACH 1
// Detected host current codes
`define TCC_HC_STANDBY 2'h0
`define TCC_HC_DEFAULT 2'h1
`define TCC_HC_MEDIUM 2'h2
`define TCC_HC_HIGH 2'h3
// Connect-detect config reset
`define TCC_CONDET_DIS_RESET 1'b1
// Strap latch interval
`define TCC_LATCH_TIME_NS 1000
`define TCC_CLK_PERIOD_NS 4
`define TCC_LATCH_CYCLES \
    ((`TCC_LATCH_TIME_NS + `TCC_CLK_PERIOD_NS - 1) / `TCC_CLK_PERIOD_NS)
`endif

// ==== hw/tcc_strap.v ====
`timescale 1ns/100ps
`include "tcc_regs.vh"
module tcc_strap
(
    input wire clk,
    input wire reset_n,
    input wire adr_pulled,
    input wire [1:0] role_pin,
    output reg latched,
    output reg i2c_mode,
    output reg [1:0] role_strap
);
    localparam integer LATCH_CYCLES = `TCC_LATCH_CYCLES;
    localparam [9:0] LATCH_LAST = LATCH_CYCLES[9:0] - 10'h001;
    reg [9:0] count;
    // Straps caught by clocked logic until the latch interval ends
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= 10'h000;
            latched <= 1'b0;
            i2c_mode <= 1'b0;
            role_strap <= 2'h0;
        end
        else if (!latched)
        begin
            i2c_mode <= adr_pulled;
            role_strap <= role_pin;
            if (count == LATCH_LAST)
                latched <= 1'b1;
            else
                count <= count + 10'h001;
        end
    end
endmodule

// ==== hw/tcc_event.v ====
`timescale 1ns/100ps
`include "tcc_regs.vh"
module tcc_event
(
    input wire clk,
    input wire reset_n,
    input wire set_pulse,
    input wire clear_pulse,
    output reg flag
);
    // Set beats clear in the same cycle
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            flag <= 1'b0;
        else if (set_pulse)
            flag <= 1'b1;
        else if (clear_pulse)
            flag <= 1'b0;
    end
endmodule

// ==== hw/tcc_control.v ====
// Operation
// - In UFP role, capture host pull-up current into readable status.
// - In pin mode, current indicators show detected host current.
// - Address strap is input at power-up, then connect-detect output.
// - Connect-detect output disabled after reset via config bit0, which resets to one.
// - Attach or detach in any role pulses connect-detect if enabled.
// - Signalled attach and detach events also recorded in status.
// - Report VCONN line in two bits and raise interrupt.
// - Strap sensed pulled selects I2C mode, floating selects pin mode.
// - In I2C mode the three indicator outputs are not driven.
// - In I2C mode role pin sampled once at power-up.
// - In pin mode role follows role pin until the control register is written.
// - In pin mode third indicator signals audio accessory detected.
// - Configuration pins sampled at power-up into register defaults.
// - Register writes override pin-set configuration.
// - Source current field: 00 default, 01 medium, 10 high.
// - Role field 00 UFP, 01 DFP, 10 DRP; resets to pin.
// - Mask bit resets zero; one masks attach and detach interrupts.
// - Status bit1 detach, bit0 attach; cleared on read.
// - Events and host current changes pull interrupt low.
// - Indicator pair: 00 high, 10 medium, 11 default.
`timescale 1ns/100ps
`include "tcc_regs.vh"
module tcc_control
(
    input wire clk,
    input wire reset_n,
    input wire adr_pulled,
    input wire [1:0] role_pin,
    input wire attach_event,
    input wire detach_event,
    input wire [1:0] host_current,
    input wire audio_detect,
    input wire [1:0] vconn_need,
    input wire [7:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire i2c_mode,
    output wire strap_latched,
    output wire [1:0] active_role,
    output wire [1:0] source_current,
    output reg connect_detect_out,
    output wire connect_detect_oe,
    output wire current_ind_a,
    output wire current_ind_a_oe,
    output wire current_ind_b,
    output wire current_ind_b_oe,
    output wire audio_detect_out,
    output wire audio_detect_oe,
    output wire irq_n
);
    wire latched;
    wire mode_i2c;
    wire [1:0] role_strap;
    wire ev_attach;
    wire ev_detach;
    wire [1:0] ev_set;
    wire [1:0] ev_flag;
    reg [1:0] ctl_rp;
    reg [1:0] ctl_role;
    reg ctl_mask;
    reg role_written;
    reg condet_dis;
    reg [1:0] host_cur_stat;
    reg [1:0] vconn_stat;
    reg cur_change;
    reg vconn_change;
    reg [1:0] next_host_cur;
    wire rd_event;
    wire rd_vconn;
    wire wr_ctl;
    wire any_event;

    assign rd_event = reg_read && (reg_addr == `TCC_ADDR_EVENT);
    assign rd_vconn = reg_read && (reg_addr == `TCC_ADDR_VCONN);
    assign wr_ctl = reg_write && (reg_addr == `TCC_ADDR_CONTROL);
    assign any_event = attach_event || detach_event;

    tcc_strap tcc_strap_inst
    (
        .clk(clk),
        .reset_n(reset_n),
        .adr_pulled(adr_pulled),
        .role_pin(role_pin),
        .latched(latched),
        .i2c_mode(mode_i2c),
        .role_strap(role_strap)
    );

    // Event flags, one per status bit
    assign ev_set[`TCC_EV_ATTACH] = attach_event && latched;
    assign ev_set[`TCC_EV_DETACH] = detach_event && latched;

    genvar ev_idx;
    generate
        for (ev_idx = 0; ev_idx < 2; ev_idx = ev_idx + 1)
        begin : ev_bit
            tcc_event tcc_event_inst
            (
                .clk(clk),
                .reset_n(reset_n),
                .set_pulse(ev_set[ev_idx]),
                .clear_pulse(rd_event),
                .flag(ev_flag[ev_idx])
            );
        end
    endgenerate

    assign ev_attach = ev_flag[`TCC_EV_ATTACH];
    assign ev_detach = ev_flag[`TCC_EV_DETACH];

    assign i2c_mode = mode_i2c;
    assign strap_latched = latched;
    assign source_current = ctl_rp;

    // Active role: written value, else strap, else live pin in pin mode
    assign active_role = role_written ? ctl_role :
        (mode_i2c ? ctl_role : role_pin);

    // Detected host current, only while acting as UFP
    always @*
    begin
        next_host_cur = host_cur_stat;
        if (active_role == `TCC_ROLE_UFP)
            next_host_cur = host_current;
    end

    // Control and configuration registers
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_rp <= `TCC_RP_DEFAULT;
            ctl_role <= `TCC_ROLE_UFP;
            ctl_mask <= 1'b0;
            role_written <= 1'b0;
            condet_dis <= `TCC_CONDET_DIS_RESET;
        end
        else if (!latched)
        begin
            ctl_role <= role_strap;
        end
        else
        begin
            if (wr_ctl)
            begin
                ctl_rp <= reg_wdata[`TCC_CTL_RP_HI:`TCC_CTL_RP_LO];
                ctl_role <= reg_wdata[`TCC_CTL_ROLE_HI:`TCC_CTL_ROLE_LO];
                role_written <= 1'b1;
                ctl_mask <= reg_wdata[`TCC_CTL_MASK];
            end
            else if (!mode_i2c && !role_written)
            begin
                ctl_role <= role_pin;
            end
            if (reg_write && (reg_addr == `TCC_ADDR_CONDET_CFG))
                condet_dis <= reg_wdata[0];
        end
    end

    // Status capture and change flags, set wins over read clear
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            host_cur_stat <= `TCC_HC_STANDBY;
            vconn_stat <= 2'h0;
            cur_change <= 1'b0;
            vconn_change <= 1'b0;
        end
        else if (latched)
        begin
            host_cur_stat <= next_host_cur;
            vconn_stat <= vconn_need;
            if (next_host_cur != host_cur_stat)
                cur_change <= 1'b1;
            else if (reg_read && reg_addr == `TCC_ADDR_CC_STATUS)
                cur_change <= 1'b0;
            if (vconn_need != vconn_stat)
                vconn_change <= 1'b1;
            else if (rd_vconn)
                vconn_change <= 1'b0;
        end
    end

    // Connect-detect pulse, pin is strap input until latched
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            connect_detect_out <= 1'b0;
        else
            connect_detect_out <= latched && !condet_dis && any_event;
    end
    assign connect_detect_oe = latched && !condet_dis;

    // Indicator outputs, open drain: drive low only in pin mode
    wire ind_en;
    assign ind_en = latched && !mode_i2c;
    assign current_ind_a = 1'b0;
    assign current_ind_b = 1'b0;
    assign audio_detect_out = 1'b0;
    // Pair b,a: high 00, medium 10, default 11
    assign current_ind_a_oe = ind_en &&
        ((host_cur_stat == `TCC_HC_HIGH) ||
        (host_cur_stat == `TCC_HC_MEDIUM));
    assign current_ind_b_oe = ind_en &&
        (host_cur_stat == `TCC_HC_HIGH);
    assign audio_detect_oe = ind_en && audio_detect;

    // Interrupt: low while any unmasked cause pending
    assign irq_n = !(((ev_attach || ev_detach) && !ctl_mask) ||
        cur_change || vconn_change);

    // Read data
    always @*
    begin
        case (reg_addr)
            `TCC_ADDR_IDENTITY:
                reg_rdata = {`TCC_DEV_VERSION, `TCC_VENDOR};
            `TCC_ADDR_CONTROL:
                reg_rdata = {3'h0, ctl_rp, active_role, ctl_mask};
            `TCC_ADDR_EVENT:
                reg_rdata = {6'h00, ev_detach, ev_attach};
            `TCC_ADDR_CC_STATUS:
                reg_rdata = {1'b0, host_cur_stat, 5'h00};
            `TCC_ADDR_CONDET_CFG:
                reg_rdata = {7'h00, condet_dis};
            `TCC_ADDR_VCONN:
                reg_rdata = {6'h00, vconn_stat};
            default:
                reg_rdata = 8'h00;
        endcase
    end
endmodule

// ==== test/tcc_asserts.sv ====
`timescale 1ns/100ps
`include "tcc_regs.vh"
module tcc_asserts
(
    input wire clk,
    input wire reset_n,
    input wire attach_event,
    input wire detach_event,
    input wire [1:0] host_current,
    input wire [1:0] active_role,
    input wire audio_detect,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire i2c_mode,
    input wire strap_latched,
    input wire connect_detect_out,
    input wire connect_detect_oe,
    input wire current_ind_a_oe,
    input wire current_ind_b_oe,
    input wire audio_detect_oe,
    input wire irq_n
);
    wire ev = attach_event | detach_event;
    wire pin = strap_latched & !i2c_mode;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    condet_pulse_a: assert property (ev && connect_detect_oe
        |=> connect_detect_out) else $error("no connect pulse");
    condet_cause_a: assert property (connect_detect_out
        |-> $past(ev)) else $error("stray connect pulse");
    pins_free_a: assert property (i2c_mode
        |-> !(current_ind_a_oe | current_ind_b_oe | audio_detect_oe))
        else $error("indicator driven in bus mode");
    strap_input_a: assert property (!strap_latched
        |-> !connect_detect_oe) else $error("strap pin driven early");
    mode_hold_a: assert property (strap_latched
        && $past(strap_latched) |-> i2c_mode == $past(i2c_mode))
        else $error("mode changed");
    audio_pin_a: assert property (pin
        |-> audio_detect_oe == audio_detect) else $error("audio indicator");
    ind_high_a: assert property (pin && active_role == `TCC_ROLE_UFP
        && host_current == `TCC_HC_HIGH |=> current_ind_a_oe
        && current_ind_b_oe) else $error("high code");
    ind_dflt_a: assert property (pin && active_role == `TCC_ROLE_UFP
        && host_current == `TCC_HC_DEFAULT |=> !current_ind_a_oe
        && !current_ind_b_oe) else $error("default code");
    irq_current_a: assert property (strap_latched
        && $past(strap_latched) && active_role == `TCC_ROLE_UFP
        && $past(active_role) == `TCC_ROLE_UFP
        && host_current != $past(host_current) |-> ##[0:2] !irq_n)
        else $error("no irq on current change");
    ident_ro_a: assert property (reg_addr == `TCC_ADDR_IDENTITY
        |-> reg_rdata == {`TCC_DEV_VERSION, `TCC_VENDOR}) else $error("ident");
endmodule

// ==== test/tcc_cc_model.sv ====
`timescale 1ns/100ps
module tcc_cc_model
(
    input wire clk,
    input wire [1:0] kick,
    output reg attach_event,
    output reg detach_event
);
    initial
    begin
        attach_event = 1'b0;
        detach_event = 1'b0;
    end
    // One-cycle event pulses, launched just after the edge
    always @(posedge clk)
    begin
        attach_event <= kick[0];
        detach_event <= kick[1];
    end
endmodule

// ==== test/typec_cc_control_status_tb_top.sv ====
`timescale 1ns/100ps
`include "tcc_regs.vh"
module typec_cc_control_status_tb_top;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg adr_pulled = 1'b1;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg audio_detect = 1'b0;
    reg [1:0] role_pin = 2'h0, kick = 2'h0;
    reg [1:0] host_current = 2'h0, vconn_need = 2'h0;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v;
    reg [1:0] r;
    wire [7:0] reg_rdata;
    wire [1:0] active_role, source_current;
    wire attach_event, detach_event, i2c_mode, strap_latched, irq_n;
    wire connect_detect_out, connect_detect_oe, audio_detect_oe;
    wire current_ind_a_oe, current_ind_b_oe;
    integer bad_count = 0, num_checks = 0, seed = 32'h2FDF, i, t, u;
    always #2 clk = ~clk;
    tcc_cc_model tcc_cc_model_inst (.clk(clk), .kick(kick),
        .attach_event(attach_event), .detach_event(detach_event));
    tcc_control tcc_control_inst (.clk(clk), .reset_n(reset_n),
        .adr_pulled(adr_pulled), .role_pin(role_pin),
        .attach_event(attach_event), .detach_event(detach_event),
        .host_current(host_current), .audio_detect(audio_detect),
        .vconn_need(vconn_need), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .i2c_mode(i2c_mode), .strap_latched(strap_latched),
        .active_role(active_role), .source_current(source_current),
        .connect_detect_out(connect_detect_out),
        .connect_detect_oe(connect_detect_oe), .current_ind_a(),
        .current_ind_a_oe(current_ind_a_oe), .current_ind_b(),
        .current_ind_b_oe(current_ind_b_oe), .audio_detect_out(),
        .audio_detect_oe(audio_detect_oe), .irq_n(irq_n));
    function [7:0] ctl_exp(input [1:0] rp, input [1:0] role, input m);
        ctl_exp = {3'h0, rp, role, m};
    endfunction
    function [7:0] ind_exp(input [1:0] hc);
        ind_exp = hc == `TCC_HC_HIGH ? 8'h00 :
            (hc == `TCC_HC_MEDIUM ? 8'h02 : 8'h03);
    endfunction
    task complete_run;
    begin
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    task check8(input [7:0] got, input [7:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        @(negedge clk);
    end
    endtask
    task rd(input [7:0] a, input [7:0] e);
    begin
        reg_addr = a;
        reg_read = 1'b1;
        #1 check8(reg_rdata, e);
        @(negedge clk);
        reg_read = 1'b0;
        @(negedge clk);
    end
    endtask
    task fire(input [1:0] k, input p);
    begin
        kick = k;
        @(negedge clk);
        kick = 2'h0;
        @(negedge clk);
        check8({7'h0, connect_detect_out}, {7'h0, p});
        @(negedge clk);
    end
    endtask
    task start(input adr);
    begin
        reset_n = 1'b0;
        adr_pulled = adr;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        i = 0;
        while (!strap_latched && i < 400)
        begin
            @(negedge clk);
            i = i + 1;
        end
        if (i == 400)
        begin
            bad_count = bad_count + 1;
            $display("Error at %0t: strap never latched", $time);
            complete_run;
        end
    end
    endtask
    initial
    begin
        t = $unsigned($random(seed)) % 3;
        r = t[1:0];
        role_pin = r;
        start(1'b1);
        check8({6'h0, i2c_mode, connect_detect_oe}, 8'h02);
        rd(`TCC_ADDR_CC_STATUS, 8'h00);
        rd(`TCC_ADDR_VCONN, 8'h00);
        wr(`TCC_ADDR_IDENTITY, 8'hFF);
        rd(`TCC_ADDR_IDENTITY, {`TCC_DEV_VERSION, `TCC_VENDOR});
        role_pin = 2'h2 - r;
        rd(`TCC_ADDR_CONTROL, ctl_exp(2'h0, r, 1'b0));
        rd(`TCC_ADDR_EVENT, 8'h00);
        rd(`TCC_ADDR_CONDET_CFG, 8'h01);
        rd(8'h05, 8'h00);
        fire(2'h1, 1'b0);
        rd(`TCC_ADDR_EVENT, 8'h01);
        wr(`TCC_ADDR_CONDET_CFG, 8'h00);
        check8({7'h0, connect_detect_oe}, 8'h01);
        for (i = 1; i < 3; i = i + 1)
        begin
            fire(i[1:0], 1'b1);
            check8({7'h0, irq_n}, 8'h00);
            rd(`TCC_ADDR_EVENT, i[7:0]);
            rd(`TCC_ADDR_EVENT, 8'h00);
            check8({7'h0, irq_n}, 8'h01);
        end
        wr(`TCC_ADDR_CONTROL, ctl_exp(2'h0, r, 1'b1));
        fire(2'h1, 1'b1);
        check8({7'h0, irq_n}, 8'h01);
        kick = 2'h1;
        @(negedge clk);
        kick = 2'h0;
        rd(`TCC_ADDR_EVENT, 8'h01);
        rd(`TCC_ADDR_EVENT, 8'h01);
        rd(`TCC_ADDR_EVENT, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            t = $unsigned($random(seed)) % 3;
            u = i % 3;
            v = ctl_exp(t[1:0], u[1:0], 1'b0);
            wr(`TCC_ADDR_CONTROL, v);
            rd(`TCC_ADDR_CONTROL, v);
            check8({4'h0, source_current, active_role},
                {4'h0, v[4:1]});
        end
        wr(`TCC_ADDR_CONTROL, 8'h00);
        t = $unsigned($random(seed)) % 3;
        host_current = host_current + 2'h1 + t[1:0];
        t = $unsigned($random(seed)) % 2;
        vconn_need = 2'h1 + t[1:0];
        repeat (3) @(negedge clk);
        check8({7'h0, irq_n}, 8'h00);
        rd(`TCC_ADDR_CC_STATUS, {1'b0, host_current, 5'h00});
        rd(`TCC_ADDR_VCONN, {6'h00, vconn_need});
        check8({7'h0, irq_n}, 8'h01);
        start(1'b0);
        check8({6'h0, i2c_mode, connect_detect_oe}, 8'h00);
        for (i = 0; i < 3; i = i + 1)
        begin
            role_pin = i[1:0];
            t = $random(seed);
            audio_detect = t[0];
            @(negedge clk);
            check8({6'h0, active_role}, i[7:0]);
            check8({7'h0, audio_detect_oe}, {7'h0, t[0]});
        end
        role_pin = 2'h0;
        for (i = 1; i < 4; i = i + 1)
        begin
            host_current = i[1:0];
            @(negedge clk);
            check8({6'h0, !current_ind_b_oe, !current_ind_a_oe},
                ind_exp(i[1:0]));
        end
        complete_run;
    end
endmodule
bind tcc_control tcc_asserts tcc_asserts_inst (.clk(clk), .reset_n(reset_n),
    .active_role(active_role),
    .attach_event(attach_event), .detach_event(detach_event),
    .host_current(host_current), .audio_detect(audio_detect),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .i2c_mode(i2c_mode),
    .strap_latched(strap_latched), .connect_detect_out(connect_detect_out),
    .connect_detect_oe(connect_detect_oe), .current_ind_a_oe(current_ind_a_oe),
    .current_ind_b_oe(current_ind_b_oe), .audio_detect_oe(audio_detect_oe),
    .irq_n(irq_n));
